// file: dpd_map.svh
// Register offsets, field positions, reset values and timing counts of the power-down block
`ifndef DPD_MAP_SVH
`define DPD_MAP_SVH
`define DPD_ADDR_CTRL 4'h0
`define DPD_ADDR_STAT 4'h4
`define DPD_ADDR_REFC 4'h8
`define DPD_CTRL_FAST_BIT 0
`define DPD_CTRL_UNK_BIT 1
`define DPD_CTRL_RST 1'b0
`define DPD_STAT_STATE_LSB 0
`define DPD_STAT_BANK_LSB 8
`define DPD_STAT_DLL_BIT 16
`define DPD_STAT_ODTA_BIT 17
`define DPD_STAT_UNK_BIT 18
`define DPD_CK_NS 80
`define DPD_TXPDLL_NS 24
`define DPD_TXPDLL_MIN_CK 10
`define DPD_TXPDLL_NS_CK ((`DPD_TXPDLL_NS + `DPD_CK_NS - 1) / `DPD_CK_NS)
`define DPD_TXPDLL_CK ((`DPD_TXPDLL_NS_CK > `DPD_TXPDLL_MIN_CK) ? `DPD_TXPDLL_NS_CK : `DPD_TXPDLL_MIN_CK)
`endif

// file: dpd_pkg.sv
// Types shared by the power-down block
package dpd_pkg;
  typedef enum logic [4:0] {
    DPD_NORMAL  = 5'h01,
    DPD_PD_ACT  = 5'h02,
    DPD_PD_FAST = 5'h04,
    DPD_PD_SLOW = 5'h08,
    DPD_RESET   = 5'h10
  } dpd_state_e;

  typedef struct packed {
    logic ck;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic a10;
    logic [2:0] ba;
    logic odt;
    logic reset_n;
  } dpd_pin_s;
endpackage : dpd_pkg

// file: dpd_sync.sv
// Two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/10ps
`default_nettype none
module dpd_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          meta_ff[i] <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          meta_ff[i] <= din[i];
          dout[i] <= meta_ff[i];
        end
      end
    end
  endgenerate
endmodule : dpd_sync
`default_nettype wire

// file: dpd_top.sv
// Power-down entry/exit and reset handling inside the DRAM
//
// Functional notes
// - Power-down entered at clock edge with CKE low and NOP or DES.
// - Power-down disables buffers except clock, ODT, CKE, reset; only NOP/DES.
// - Any bank open gives active power-down, else precharge power-down.
// - Precharge power-down: DLL off on slow exit mode, on in fast.
// - Reset low during power-down leaves it and enters reset state.
// - Exit at clock edge with CKE high and NOP or DES; hold tCKE.
// - Slow exit precharge power-down makes ODT asynchronous until tXPDLL.
// - Reset low acts at any time; held low at least 100 ns.
// - Under reset: outputs off, termination off, refresh counters cleared.
`timescale 1ns/10ps
`default_nettype none
`include "dpd_map.svh"
module dpd_top (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire dpd_pkg::dpd_pin_s pins,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic in_buf_en,
  output logic out_en,
  output logic rtt_en,
  output logic dll_on,
  output logic odt_async,
  output logic in_reset
);
  localparam int PW = $bits(dpd_pkg::dpd_pin_s);
  localparam logic [3:0] XPDLL_CK = 4'(`DPD_TXPDLL_CK);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisation
  logic [1:0] rst_ff;
  logic rst_n;
  logic [PW-1:0] pin_sync;
  dpd_pkg::dpd_pin_s ps;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) rst_ff <= 2'h0;
    else rst_ff <= {rst_ff[0], 1'b1};
  end
  assign rst_n = rst_ff[1];

  dpd_sync #(.W(PW)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din(pins),
    .dout(pin_sync)
  );
  assign ps = dpd_pkg::dpd_pin_s'(pin_sync);

  ////////////////////////////////////////////////////////////////////////////
  // Link clock edge and command decode
  logic ck_prev_ff;
  logic cke_prev_ff;
  wire ck_rise = ps.ck & ~ck_prev_ff;
  wire cmd_nop = ps.cs_n | (ps.ras_n & ps.cas_n & ps.we_n);
  wire cmd_vld = ck_rise & cke_prev_ff & ps.cke & ~ps.cs_n;
  wire cmd_act = cmd_vld & ~ps.ras_n & ps.cas_n & ps.we_n;
  wire cmd_pre = cmd_vld & ~ps.ras_n & ps.cas_n & ~ps.we_n;
  wire cmd_ref = cmd_vld & ~ps.ras_n & ~ps.cas_n & ps.we_n;
  wire cmd_rw = cmd_vld & ps.ras_n & ~ps.cas_n;
  wire pin_rst = ~ps.reset_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ck_prev_ff <= 1'b0;
      cke_prev_ff <= 1'b0;
    end else begin
      ck_prev_ff <= ps.ck;
      if (ck_rise) cke_prev_ff <= ps.cke;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank tracking and refresh counter
  logic [7:0] bank_ff;
  logic [7:0] nxt_bank;
  logic [15:0] refc_ff;
  wire [7:0] ba_dec = 8'h01 << ps.ba;

  // Auto precharge is taken as closing the bank at once; the controller's
  // entry delays cover the real precharge time
  always_comb begin
    nxt_bank = bank_ff;
    if (cmd_act) nxt_bank = bank_ff | ba_dec;
    else if (cmd_pre && ps.a10) nxt_bank = 8'h00;
    else if (cmd_pre || (cmd_rw && ps.a10)) nxt_bank = bank_ff & ~ba_dec;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bank_ff <= 8'h00;
      refc_ff <= 16'h0000;
    end else if (pin_rst) begin
      bank_ff <= 8'h00;
      refc_ff <= 16'h0000;
    end else begin
      bank_ff <= nxt_bank;
      if (cmd_ref) refc_ff <= refc_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down state machine
  dpd_pkg::dpd_state_e state_ff;
  dpd_pkg::dpd_state_e nxt_state;
  logic fast_ff;
  logic unk_ff;
  logic [3:0] xp_cnt_ff;
  wire in_pd = (state_ff == dpd_pkg::DPD_PD_ACT) | (state_ff == dpd_pkg::DPD_PD_FAST) |
               (state_ff == dpd_pkg::DPD_PD_SLOW);
  wire pd_entry = (state_ff == dpd_pkg::DPD_NORMAL) & ck_rise & cke_prev_ff & ~ps.cke & cmd_nop;
  wire pd_exit = in_pd & ck_rise & ~cke_prev_ff & ps.cke & cmd_nop;
  wire slow_exit = pd_exit & (state_ff == dpd_pkg::DPD_PD_SLOW);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      dpd_pkg::DPD_NORMAL: begin
        if (pd_entry) begin
          if (|bank_ff) nxt_state = dpd_pkg::DPD_PD_ACT;
          else if (fast_ff) nxt_state = dpd_pkg::DPD_PD_FAST;
          else nxt_state = dpd_pkg::DPD_PD_SLOW;
        end
      end
      dpd_pkg::DPD_PD_ACT, dpd_pkg::DPD_PD_FAST, dpd_pkg::DPD_PD_SLOW: begin
        if (pd_exit) nxt_state = dpd_pkg::DPD_NORMAL;
      end
      dpd_pkg::DPD_RESET: begin
        // Back to normal only once the pin is high; contents stay unknown
        nxt_state = dpd_pkg::DPD_NORMAL;
      end
    endcase
    if (pin_rst) nxt_state = dpd_pkg::DPD_RESET;
  end

  // ODT stays asynchronous for tXPDLL link clocks after a slow exit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) xp_cnt_ff <= 4'h0;
    else if (slow_exit) xp_cnt_ff <= XPDLL_CK;
    else if (ck_rise && xp_cnt_ff != 4'h0) xp_cnt_ff <= xp_cnt_ff - 4'h1;
  end

  wire nxt_slow = nxt_state == dpd_pkg::DPD_PD_SLOW;
  wire nxt_norm = nxt_state == dpd_pkg::DPD_NORMAL;
  wire nxt_rst = nxt_state == dpd_pkg::DPD_RESET;
  wire nxt_odta = nxt_slow | slow_exit | (xp_cnt_ff > 4'h1) | ((xp_cnt_ff == 4'h1) & ~ck_rise);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= dpd_pkg::DPD_NORMAL;
      in_buf_en <= 1'b1;
      out_en <= 1'b1;
      rtt_en <= 1'b0;
      dll_on <= 1'b1;
      odt_async <= 1'b0;
      in_reset <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      in_buf_en <= nxt_norm;
      out_en <= nxt_norm;
      rtt_en <= ps.odt & ~nxt_rst;
      dll_on <= ~nxt_slow;
      odt_async <= nxt_odta & ~nxt_rst;
      in_reset <= nxt_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  wire wr_ctrl = reg_wr & (reg_addr == `DPD_ADDR_CTRL);
  wire unk_clr = wr_ctrl & reg_wdata[`DPD_CTRL_UNK_BIT];
  wire [31:0] stat_word = (32'(state_ff) << `DPD_STAT_STATE_LSB) |
                          (32'(bank_ff) << `DPD_STAT_BANK_LSB) |
                          (32'(dll_on) << `DPD_STAT_DLL_BIT) |
                          (32'(odt_async) << `DPD_STAT_ODTA_BIT) |
                          (32'(unk_ff) << `DPD_STAT_UNK_BIT);
  wire [31:0] ctrl_word = 32'(fast_ff) << `DPD_CTRL_FAST_BIT;
  wire [31:0] rd_mux = (reg_addr == `DPD_ADDR_CTRL) ? ctrl_word :
                       (reg_addr == `DPD_ADDR_STAT) ? stat_word :
                       (reg_addr == `DPD_ADDR_REFC) ? {16'h0000, refc_ff} : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fast_ff <= `DPD_CTRL_RST;
      unk_ff <= 1'b1;
      reg_rdata <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) fast_ff <= reg_wdata[`DPD_CTRL_FAST_BIT];
      // Reset marks data unknown; a set in the clearing cycle wins
      if (pin_rst) unk_ff <= 1'b1;
      else if (unk_clr) unk_ff <= 1'b0;
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  entry_leaves_normal_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pd_entry && ps.reset_n |=> state_ff != dpd_pkg::DPD_NORMAL && !in_buf_en)
    else $error("power-down entry not taken");
  buffers_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    in_pd |-> !in_buf_en && !out_en)
    else $error("buffers enabled in power-down");
  active_kind_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pd_entry && ps.reset_n && (bank_ff != 8'h00) |=> state_ff == dpd_pkg::DPD_PD_ACT)
    else $error("open bank did not give active power-down");
  precharge_kind_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pd_entry && ps.reset_n && (bank_ff == 8'h00) |=> state_ff != dpd_pkg::DPD_PD_ACT)
    else $error("closed banks gave active power-down");
  slow_dll_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_ff == dpd_pkg::DPD_PD_SLOW) == !dll_on)
    else $error("DLL state wrong for power-down kind");
  fast_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pd_entry && ps.reset_n && bank_ff == 8'h00 && fast_ff |=> state_ff == dpd_pkg::DPD_PD_FAST)
    else $error("fast exit mode ignored");
  reset_leaves_pd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    in_pd && pin_rst |=> state_ff == dpd_pkg::DPD_RESET && in_reset)
    else $error("reset did not end power-down");
  reset_any_time_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pin_rst |=> in_reset)
    else $error("reset pin ignored");
  reset_outputs_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    in_reset |-> !out_en && !rtt_en && refc_ff == 16'h0000 && unk_ff)
    else $error("outputs or counters live under reset");
  exit_normal_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pd_exit && ps.reset_n |=> state_ff == dpd_pkg::DPD_NORMAL ##0 in_buf_en)
    else $error("power-down exit not taken");
  async_odt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    slow_exit && ps.reset_n |=> odt_async [*8] ##1 xp_cnt_ff != 4'h0)
    else $error("ODT left asynchronous mode early");
endmodule : dpd_top
`default_nettype wire

// file: dpd_ctl_model.sv
// Memory controller model that drives the DRAM pins of the power-down block
`timescale 1ns/10ps
`default_nettype none
module dpd_ctl_model (
  output wire dpd_pkg::dpd_pin_s pins
);
  logic ck = 1'b0;
  logic cke = 1'b1;
  logic rst_n = 1'b1;
  logic odt = 1'b0;
  logic a10 = 1'b0;
  logic [3:0] cmd = 4'h7;
  logic [2:0] ba = 3'h0;
  // Plain default latencies in link clocks; a real controller takes them from its mode setup
  localparam int RD_LAT = 6;
  localparam int WR_LAT = 5;
  localparam int WR_REC = 6;
  assign pins = {ck, cke, cmd, a10, ba, odt, rst_n};
  // The clock runs free and stays stable through power-down
  initial begin
    #3;
    forever #40 ck = ~ck;
  end
  // Pins change on the falling edge, so they are steady at the rising edge
  task automatic step(input logic k, input logic [3:0] c, input logic [2:0] b, input logic a);
    @(negedge ck);
    cke <= k;
    cmd <= c;
    ba <= b;
    a10 <= a;
    @(posedge ck);
  endtask : step
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic a);
    step(1'b1, c, b, a);
    step(1'b1, 4'h7, 3'h0, 1'b0);
  endtask : issue
  // Column command, then NOP until power-down entry would be legal again
  task automatic burst(input logic [3:0] c, input logic [2:0] b, input logic a, input logic rd);
    step(1'b1, c, b, a);
    if (rd) repeat (RD_LAT + 4 + 1) step(1'b1, 4'h7, 3'h0, 1'b0);
    else repeat (WR_LAT + 4 + WR_REC) step(1'b1, 4'h7, 3'h0, 1'b0);
  endtask : burst
  task automatic pd_enter();
    step(1'b1, 4'h7, 3'h0, 1'b0);
    step(1'b0, 4'h7, 3'h0, 1'b0);
    // Other inputs are a don't-care here, so the bank lines are scrambled
    repeat (3) step(1'b0, 4'h7, 3'h5, 1'b1);
  endtask : pd_enter
  task automatic pd_exit();
    step(1'b1, 4'h7, 3'h0, 1'b0);
    // Entry always happens with the DLL locked, so no DLL reset follows exit
    repeat (3) step(1'b1, 4'h7, 3'h0, 1'b0);
  endtask : pd_exit
  task automatic rst_set(input logic v);
    @(negedge ck);
    cke <= 1'b0;
    rst_n <= v;
    repeat (2) @(posedge ck);
  endtask : rst_set
  task automatic set_odt(input logic v);
    @(negedge ck);
    odt <= v;
  endtask : set_odt
endmodule : dpd_ctl_model
`default_nettype wire

// file: dpd_tb.sv
// Self-checking testbench of the power-down block
`timescale 1ns/10ps
`default_nettype none
`include "dpd_map.svh"
module tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic in_buf_en, out_en, rtt_en, dll_on, odt_async, in_reset;
  logic [31:0] v;
  dpd_pkg::dpd_pin_s pins;
  int n_mismatch = 0;
  int tests_run = 0;
  dpd_ctl_model ctl_u (.pins(pins));
  dpd_top dut_u (.clk_sys(clk_sys), .rstn(rstn), .pins(pins), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in_buf_en(in_buf_en), .out_en(out_en), .rtt_en(rtt_en), .dll_on(dll_on),
    .odt_async(odt_async), .in_reset(in_reset));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", w, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic chk_reg(input string w, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] r;
    rd(a, r);
    chk(w, r, exp);
  endtask : chk_reg
  function automatic logic [31:0] st(input logic [4:0] s, input logic [7:0] m,
    input logic dl, input logic oa, input logic uk);
    return {13'h0, uk, oa, dl, m, 3'h0, s};
  endfunction : st
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    chk_reg("ctrl", `DPD_ADDR_CTRL, 32'h0);
    chk_reg("unmapped", 4'hc, 32'h0);
    chk_reg("status", `DPD_ADDR_STAT, st(5'h01, 8'h00, 1'b1, 1'b0, 1'b1));
    wr(`DPD_ADDR_CTRL, 32'h3);
    chk_reg("ctrl", `DPD_ADDR_CTRL, 32'h1);
    chk_reg("status", `DPD_ADDR_STAT, st(5'h01, 8'h00, 1'b1, 1'b0, 1'b0));
  endtask : t_regs
  task automatic t_active();
    ctl_u.issue(4'h3, 3'h2, 1'b0);
    ctl_u.pd_enter();
    chk_reg("status", `DPD_ADDR_STAT, st(5'h02, 8'h04, 1'b1, 1'b0, 1'b0));
    chk("in_buf_en", {31'h0, in_buf_en}, 32'h0);
    chk("out_en", {31'h0, out_en}, 32'h0);
    ctl_u.pd_exit();
    chk_reg("status", `DPD_ADDR_STAT, st(5'h01, 8'h04, 1'b1, 1'b0, 1'b0));
    chk("in_buf_en", {31'h0, in_buf_en}, 32'h1);
    ctl_u.issue(4'h3, 3'h3, 1'b0);
    ctl_u.burst(4'h5, 3'h2, 1'b1, 1'b1);
    chk_reg("rdap", `DPD_ADDR_STAT, st(5'h01, 8'h08, 1'b1, 1'b0, 1'b0));
    ctl_u.burst(4'h4, 3'h3, 1'b0, 1'b0);
    chk_reg("write", `DPD_ADDR_STAT, st(5'h01, 8'h08, 1'b1, 1'b0, 1'b0));
    // Precharge with the all-banks line set closes every bank
    ctl_u.issue(4'h2, 3'h0, 1'b1);
    chk_reg("status", `DPD_ADDR_STAT, st(5'h01, 8'h00, 1'b1, 1'b0, 1'b0));
  endtask : t_active
  task automatic t_refuse();
    ctl_u.step(1'b1, 4'h7, 3'h0, 1'b0);
    ctl_u.step(1'b0, 4'h3, 3'h1, 1'b0);
    ctl_u.step(1'b0, 4'h7, 3'h0, 1'b0);
    chk_reg("refused", `DPD_ADDR_STAT, st(5'h01, 8'h00, 1'b1, 1'b0, 1'b0));
    ctl_u.step(1'b1, 4'h7, 3'h0, 1'b0);
  endtask : t_refuse
  task automatic t_fast();
    ctl_u.pd_enter();
    chk_reg("status", `DPD_ADDR_STAT, st(5'h04, 8'h00, 1'b1, 1'b0, 1'b0));
    chk("dll_on", {31'h0, dll_on}, 32'h1);
    ctl_u.pd_exit();
    chk_reg("status", `DPD_ADDR_STAT, st(5'h01, 8'h00, 1'b1, 1'b0, 1'b0));
  endtask : t_fast
  task automatic t_slow();
    wr(`DPD_ADDR_CTRL, 32'h0);
    ctl_u.pd_enter();
    chk_reg("status", `DPD_ADDR_STAT, st(5'h08, 8'h00, 1'b0, 1'b1, 1'b0));
    chk("dll_on", {31'h0, dll_on}, 32'h0);
    ctl_u.pd_exit();
    repeat (4) @(posedge pins.ck);
    chk("dll_on", {31'h0, dll_on}, 32'h1);
    chk("odt_async", {31'h0, odt_async}, 32'h1);
    repeat (6) @(posedge pins.ck);
    chk("odt_async", {31'h0, odt_async}, 32'h0);
  endtask : t_slow
  task automatic t_reset();
    ctl_u.set_odt(1'b1);
    repeat (3) ctl_u.issue(4'h1, 3'h0, 1'b0);
    chk_reg("refcnt", `DPD_ADDR_REFC, 32'h3);
    chk("rtt_en", {31'h0, rtt_en}, 32'h1);
    ctl_u.pd_enter();
    ctl_u.rst_set(1'b0);
    chk("in_reset", {31'h0, in_reset}, 32'h1);
    chk("out_en", {31'h0, out_en}, 32'h0);
    chk("rtt_en", {31'h0, rtt_en}, 32'h0);
    rd(`DPD_ADDR_STAT, v);
    chk("status", v & 32'h0004ff1f, 32'h00040010);
    chk_reg("refcnt", `DPD_ADDR_REFC, 32'h0);
    ctl_u.rst_set(1'b1);
    chk("in_reset", {31'h0, in_reset}, 32'h0);
    ctl_u.set_odt(1'b0);
  endtask : t_reset
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    t_regs();
    t_active();
    t_refuse();
    t_fast();
    t_slow();
    t_reset();
    tally_and_finish();
  end
  // Whole run needs about 8 us of link traffic
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
